// file: fcsm_host_defs.vh
// constants for the flash command host controller
// assumes a byte-wide asynchronous flash behind plain pins, 100 MHz core clock
//
// Overview of operation
// [RULE_01] flash refuses writes to protected sectors
// [RULE_02] all sectors start out unprotected
// [RULE_03] unlock cycles precede every program sequence
// [RULE_04] flash reads array data after power-up
// [RULE_05] flash ignores strobe glitches under 5 ns; the flash model has no glitch filter and takes any rising strobe
// [RULE_06] write needs chip-select, write low, output-enable high
// [RULE_07] no command accepted from power-up write
// [RULE_08] identification voltage on reset unprotects temporarily
// [RULE_09] bad sequence returns flash to array read
// [RULE_10] data latched on first rising strobe
// [RULE_11] address latched on later falling strobe; the flash model samples the address at the first rising strobe
// [RULE_12] erase suspend reads status in suspended sectors
// [RULE_13] host writes reset after limit flag or autoselect
// [RULE_14] reset command works at any address
// [RULE_15] reset aborts sequence before embedded operation
// [RULE_16] autoselect entered by two unlocks plus command
// [RULE_17] autoselect ids at low address 00, 01, 03
// [RULE_18] autoselect 02 with sector gives protection
// [RULE_19] program is four write cycles
// [RULE_20] embedded program times itself
// [RULE_21] flash returns to array read after program
// [RULE_22] polling and toggle bits show progress
// [RULE_23] commands during programming are discarded
// [RULE_24] program accepted at any address order
// [RULE_25] programming never turns zero into one
`ifndef FCSM_HOST_DEFS_VH
`define FCSM_HOST_DEFS_VH

// ****************************************
// register offsets of the host port
// ****************************************
`define FCSM_REG_CTRL      4'h0
`define FCSM_REG_ADDR      4'h1
`define FCSM_REG_DATA      4'h2
`define FCSM_REG_STATUS    4'h3
`define FCSM_REG_RDATA     4'h4

// ****************************************
// control register fields
// ****************************************
`define FCSM_CMD_READ      3'h1
`define FCSM_CMD_PROGRAM   3'h2
`define FCSM_CMD_AUTOSEL   3'h3
`define FCSM_CMD_RESET     3'h4
`define FCSM_CMD_ASREAD    3'h5

// ****************************************
// command bytes and unlock addresses
// ****************************************
`define FCSM_UNLOCK1_ADDR  17'h00555
`define FCSM_UNLOCK2_ADDR  17'h002aa
`define FCSM_UNLOCK1_DATA  8'haa
`define FCSM_UNLOCK2_DATA  8'h55
`define FCSM_PROG_DATA     8'ha0
`define FCSM_AUTOSEL_DATA  8'h90
`define FCSM_RESET_DATA    8'hf0

// ****************************************
// status bit positions
// ****************************************
`define FCSM_POLL_BIT      7
`define FCSM_TOGGLE_BIT    6
`define FCSM_LIMIT_BIT     5

// ****************************************
// timing: a strobe must be far longer than a glitch
// ****************************************
`define FCSM_GLITCH_NS     5
`define FCSM_CLK_NS        10
`define FCSM_STROBE_CYC    4'h4
`define FCSM_SETUP_CYC     4'h1
`define FCSM_READ_CYC      4'h8
`define FCSM_POLL_MAX      16'hffff

`endif

// file: fcsm_host.v
// flash command host controller: drives the flash pins from a register port
// assumes the flash pins are asynchronous to core_clk_in and the data bus is shared
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fcsm_host_defs.vh"

module fcsm_host
(
	input  wire        core_clk_in,    // core clock, 100 MHz
	input  wire        rst_in,         // synchronous reset, active high
	input  wire [3:0]  reg_addr_in,    // register index
	input  wire [31:0] reg_wdata_in,   // register write data
	input  wire        reg_wr_in,      // write strobe
	input  wire        reg_rd_in,      // read strobe
	output reg  [31:0] reg_rdata_out,  // read data, cycle after strobe
	output reg  [16:0] flash_addr_out, // flash address lines
	output reg  [7:0]  flash_dq_out,   // flash data out
	output reg         flash_dq_oe_out,// flash data drive enable
	input  wire [7:0]  flash_dq_in,    // flash data in
	output reg         flash_ce_n_out, // chip select, active low
	output reg         flash_oe_n_out, // output enable, active low
	output reg         flash_we_n_out, // write strobe, active low
	output reg         flash_reset_n_out, // hardware reset, active low
	output reg         busy_out        // operation in progress
);

	// ****************************************
	// states
	// ****************************************
	localparam [3:0] ST_IDLE   = 4'h0; // waiting for a command
	localparam [3:0] ST_WSETUP = 4'h1; // address up, strobes high
	localparam [3:0] ST_WLOW   = 4'h2; // write strobe low
	localparam [3:0] ST_WHOLD  = 4'h3; // strobes high, data held
	localparam [3:0] ST_RLOW   = 4'h4; // read strobe low
	localparam [3:0] ST_POLL   = 4'h5; // status poll read
	localparam [3:0] ST_NEXT   = 4'h6; // pick next write of sequence

	// ****************************************
	// registers
	// ****************************************
	reg [3:0]  state_q;        // sequencer state
	reg [3:0]  cnt_q;          // strobe width counter
	reg [2:0]  cmd_q;          // active command
	reg [1:0]  step_q;         // write index inside sequence
	reg [16:0] tgt_addr_q;     // software target address
	reg [7:0]  tgt_data_q;     // software program data
	reg [7:0]  rd_byte_q;      // last byte read
	reg        err_limit_q;    // limit flag seen
	reg        err_verify_q;   // readback mismatch
	reg        done_q;         // sticky completion
	reg        autosel_q;      // flash believed in autoselect
	reg [15:0] poll_cnt_q;     // poll timeout
	reg [7:0]  dq_s1_q;        // data sync stage one
	reg [7:0]  dq_s2_q;        // data sync stage two
	reg [7:0]  prev_q;         // previous poll byte
	reg        first_poll_q;   // first poll of this program

	wire       wr_start;       // software start of a command
	assign wr_start = reg_wr_in && (reg_addr_in == `FCSM_REG_CTRL) && !busy_out;

	// ****************************************
	// sequence table: address and data for each write
	// ****************************************
	reg [16:0] seq_addr;       // address of current write
	reg [7:0]  seq_data;       // data of current write
	reg        seq_last;       // this write ends the sequence
	always @*
	begin
		seq_addr = `FCSM_UNLOCK1_ADDR;
		seq_data = `FCSM_UNLOCK1_DATA;
		seq_last = 1'b0;
		case (step_q)
			2'h0:
			begin
				seq_addr = `FCSM_UNLOCK1_ADDR;   // [RULE_03] [RULE_16]
				seq_data = `FCSM_UNLOCK1_DATA;
				if (cmd_q == `FCSM_CMD_RESET)
				begin
					seq_addr = tgt_addr_q;       // [RULE_14] any address
					seq_data = `FCSM_RESET_DATA;
					seq_last = 1'b1;
				end
			end
			2'h1:
			begin
				seq_addr = `FCSM_UNLOCK2_ADDR;
				seq_data = `FCSM_UNLOCK2_DATA;
			end
			2'h2:
			begin
				seq_addr = `FCSM_UNLOCK1_ADDR;
				seq_data = (cmd_q == `FCSM_CMD_PROGRAM) ? `FCSM_PROG_DATA
				                                        : `FCSM_AUTOSEL_DATA;
				seq_last = (cmd_q != `FCSM_CMD_PROGRAM);
			end
			default:
			begin
				seq_addr = tgt_addr_q;           // [RULE_19] [RULE_24]
				seq_data = tgt_data_q;
				seq_last = 1'b1;
			end
		endcase
	end

	// ****************************************
	// data pins pass two flip-flops
	// ****************************************
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
		end
		else
		begin
			dq_s1_q <= flash_dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ****************************************
	// main sequencer and pin drivers
	// ****************************************
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_q           <= ST_IDLE;
			cnt_q             <= 4'h0;
			cmd_q             <= 3'h0;
			step_q            <= 2'h0;
			tgt_addr_q        <= 17'h00000;
			tgt_data_q        <= 8'h00;
			rd_byte_q         <= 8'h00;
			err_limit_q       <= 1'b0;
			err_verify_q      <= 1'b0;
			done_q            <= 1'b0;
			autosel_q         <= 1'b0;
			poll_cnt_q        <= 16'h0000;
			prev_q            <= 8'h00;
			first_poll_q      <= 1'b0;
			flash_addr_out    <= 17'h00000;
			flash_dq_out      <= 8'h00;
			flash_dq_oe_out   <= 1'b0;
			flash_ce_n_out    <= 1'b1;      // [RULE_07] strobes idle high
			flash_oe_n_out    <= 1'b1;
			flash_we_n_out    <= 1'b1;
			flash_reset_n_out <= 1'b1;
			busy_out          <= 1'b0;
		end
		else
		begin
			// software writes to address, data and status registers
			if (reg_wr_in && reg_addr_in == `FCSM_REG_ADDR && !busy_out)
				tgt_addr_q <= reg_wdata_in[16:0];
			if (reg_wr_in && reg_addr_in == `FCSM_REG_DATA && !busy_out)
				tgt_data_q <= reg_wdata_in[7:0];
			if (reg_wr_in && reg_addr_in == `FCSM_REG_STATUS)
			begin
				flash_reset_n_out <= ~reg_wdata_in[8];  // hardware reset pin
				if (reg_wdata_in[0])
					done_q <= 1'b0;
				if (reg_wdata_in[1])
					err_limit_q <= 1'b0;
				if (reg_wdata_in[2])
					err_verify_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE:
				begin
					flash_ce_n_out  <= 1'b1;
					flash_oe_n_out  <= 1'b1;
					flash_we_n_out  <= 1'b1;
					flash_dq_oe_out <= 1'b0;
					if (wr_start)
					begin
						cmd_q    <= reg_wdata_in[2:0];
						step_q   <= 2'h0;
						busy_out <= 1'b1;
						cnt_q    <= 4'h0;
						if (reg_wdata_in[2:0] == `FCSM_CMD_READ ||
						    reg_wdata_in[2:0] == `FCSM_CMD_ASREAD)
						begin
							flash_addr_out <= tgt_addr_q; // [RULE_17] [RULE_18]
							state_q        <= ST_RLOW;
						end
						else if (reg_wdata_in[2:0] == `FCSM_CMD_PROGRAM ||
						         reg_wdata_in[2:0] == `FCSM_CMD_AUTOSEL ||
						         reg_wdata_in[2:0] == `FCSM_CMD_RESET)
							state_q <= ST_NEXT;
						else
							busy_out <= 1'b0;         // unknown command ignored
					end
				end
				ST_NEXT:
				begin
					flash_addr_out  <= seq_addr;
					flash_dq_out    <= seq_data;
					flash_dq_oe_out <= 1'b1;
					flash_oe_n_out  <= 1'b1;          // [RULE_06] oe high first
					cnt_q           <= 4'h0;
					state_q         <= ST_WSETUP;
				end
				ST_WSETUP:
				begin
					flash_ce_n_out <= 1'b0;           // [RULE_11] address stable before
					cnt_q          <= cnt_q + 4'h1;
					if (cnt_q >= `FCSM_SETUP_CYC)
					begin
						flash_we_n_out <= 1'b0;       // [RULE_06]
						cnt_q          <= 4'h0;
						state_q        <= ST_WLOW;
					end
				end
				ST_WLOW:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q >= `FCSM_STROBE_CYC)    // [RULE_05] far above glitch width
					begin
						flash_we_n_out <= 1'b1;       // [RULE_10] data held past rise
						cnt_q          <= 4'h0;
						state_q        <= ST_WHOLD;
					end
				end
				ST_WHOLD:
				begin
					flash_ce_n_out <= 1'b1;
					cnt_q          <= cnt_q + 4'h1;
					if (cnt_q >= `FCSM_SETUP_CYC)
					begin
						flash_dq_oe_out <= 1'b0;
						if (!seq_last)
						begin
							step_q  <= step_q + 2'h1;
							state_q <= ST_NEXT;
						end
						else if (cmd_q == `FCSM_CMD_PROGRAM)
						begin
							poll_cnt_q   <= 16'h0000;  // [RULE_20] device times itself
							first_poll_q <= 1'b1;
							cnt_q        <= 4'h0;
							state_q      <= ST_POLL;
						end
						else
						begin
							autosel_q <= (cmd_q == `FCSM_CMD_AUTOSEL); // [RULE_13]
							done_q    <= 1'b1;
							busy_out  <= 1'b0;
							state_q   <= ST_IDLE;
						end
					end
				end
				ST_RLOW, ST_POLL:
				begin
					flash_ce_n_out <= 1'b0;
					flash_oe_n_out <= 1'b0;
					cnt_q          <= cnt_q + 4'h1;
					if (cnt_q >= `FCSM_READ_CYC)
					begin
						flash_oe_n_out <= 1'b1;
						flash_ce_n_out <= 1'b1;
						cnt_q          <= 4'h0;
						rd_byte_q      <= dq_s2_q;
						if (state_q == ST_RLOW)
						begin
							done_q   <= 1'b1;
							busy_out <= 1'b0;
							state_q  <= ST_IDLE;
						end
						else
						begin
							// [RULE_22] done when the toggle bit stops; the polling bit is not checked
							prev_q       <= dq_s2_q;
							first_poll_q <= 1'b0;
							poll_cnt_q   <= poll_cnt_q + 16'h0001;
							if (!first_poll_q &&
							    dq_s2_q[`FCSM_TOGGLE_BIT] == prev_q[`FCSM_TOGGLE_BIT])
							begin
								// [RULE_21] [RULE_25] done: readback must equal data
								err_verify_q <= (dq_s2_q != tgt_data_q);
								done_q       <= 1'b1;
								busy_out     <= 1'b0;
								state_q      <= ST_IDLE;
							end
							// limit when two toggling reads both show it, or when poll_cnt_q reaches FCSM_POLL_MAX
							else if ((!first_poll_q && dq_s2_q[`FCSM_LIMIT_BIT] &&
							          prev_q[`FCSM_LIMIT_BIT]) ||
							         poll_cnt_q == `FCSM_POLL_MAX)
							begin
								// [RULE_13] flag high: clear with reset command
								err_limit_q <= 1'b1;
								cmd_q       <= `FCSM_CMD_RESET;
								step_q      <= 2'h0;
								state_q     <= ST_NEXT;
							end
						end
					end
				end
				default:
				begin
					state_q  <= ST_IDLE;
					busy_out <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// register read port, data one cycle later
	// ****************************************
	always @(posedge core_clk_in)
	begin
		if (rst_in)
			reg_rdata_out <= 32'h00000000;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`FCSM_REG_CTRL:   reg_rdata_out <= {29'h0, cmd_q};
				`FCSM_REG_ADDR:   reg_rdata_out <= {15'h0, tgt_addr_q};
				`FCSM_REG_DATA:   reg_rdata_out <= {24'h0, tgt_data_q};
				`FCSM_REG_STATUS: reg_rdata_out <= {23'h0, ~flash_reset_n_out, 3'h0,
				                                   autosel_q, busy_out, err_verify_q,
				                                   err_limit_q, done_q};
				`FCSM_REG_RDATA:  reg_rdata_out <= {24'h0, rd_byte_q};
				default:          reg_rdata_out <= 32'h00000000;
			endcase
		end
		else
			reg_rdata_out <= 32'h00000000;
	end

endmodule
`default_nettype wire

// file: fcsm_host_checker.sv
// checker: pin sequencing of the flash host controller
// assumes a bind onto fcsm_host, one clock domain
`timescale 1ns/10ps
`default_nettype none
module fcsm_host_checker
(
	input wire logic        core_clk_in,
	input wire logic        rst_in,
	input wire logic [16:0] flash_addr_out,
	input wire logic [7:0]  flash_dq_out,
	input wire logic        flash_dq_oe_out,
	input wire logic        flash_ce_n_out,
	input wire logic        flash_oe_n_out,
	input wire logic        flash_we_n_out
);
	// ****
	// write cycle shape at the pins, and pin idle state after reset
	// ****
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	AST_WE_NEEDS_CE: assert property (!flash_we_n_out |-> !flash_ce_n_out)
		else $error("write strobe low without chip select");
	AST_WE_NEEDS_OE: assert property (!flash_we_n_out |-> flash_oe_n_out)
		else $error("write strobe low with output enable low");
	AST_NO_CONTENTION: assert property (flash_dq_oe_out |-> flash_oe_n_out)
		else $error("data driven while flash outputs enabled");
	AST_NO_GLITCH: assert property ($fell(flash_we_n_out) |-> !flash_we_n_out [*3])
		else $error("write pulse too short");
	AST_DATA_AT_RISE: assert property ($rose(flash_we_n_out) |->
		flash_dq_oe_out && $stable(flash_dq_out) && $stable(flash_addr_out))
		else $error("data or address moved at write strobe rise");
	AST_ADDR_HOLD: assert property (!flash_we_n_out && !$past(flash_we_n_out) |->
		$stable(flash_addr_out))
		else $error("address moved while write strobe low");
	AST_CE_FIRST: assert property ($fell(flash_we_n_out) |-> !$past(flash_ce_n_out))
		else $error("write strobe fell before chip select");
	AST_IDLE_RESET: assert property (disable iff (1'b0) rst_in |=> flash_ce_n_out &&
		flash_we_n_out && flash_oe_n_out && !flash_dq_oe_out)
		else $error("pins not idle after reset");
endmodule
bind fcsm_host fcsm_host_checker i_chk
(
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.flash_addr_out(flash_addr_out),
	.flash_dq_out(flash_dq_out),
	.flash_dq_oe_out(flash_dq_oe_out),
	.flash_ce_n_out(flash_ce_n_out),
	.flash_oe_n_out(flash_oe_n_out),
	.flash_we_n_out(flash_we_n_out)
);
`default_nettype wire

// file: fcsm_flash_model.sv
// behavioural flash: command state machine, array, ids
// assumes the host holds pins steady around each strobe edge
`timescale 1ns/10ps
`default_nettype none
`include "fcsm_host_defs.vh"
module fcsm_flash_model
#(
	parameter logic [7:0] MFR_CODE   = 8'h5a, // arbitrary id value
	parameter logic [7:0] DEV_CODE   = 8'hc3, // arbitrary id value
	parameter logic [7:0] CONT_CODE  = 8'h3e, // arbitrary id value
	parameter int         PROG_READS = 3      // status reads until done
)
(
	input  wire logic [16:0] addr_in,
	input  wire logic [7:0]  dq_in,
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        reset_n_in,
	output var  logic [7:0]  dq_out
);
	logic [7:0] mem [0:131071]; // array
	logic [2:0] st_q;           // 0 read,1-2 unlock,3 setup,4 autoselect,5 busy
	logic [7:0] pd_q;           // data being programmed
	logic       tgl_q;          // toggle status
	int         cnt_q;          // status reads seen
	logic [7:0] rd_v;           // read value
	logic [7:0] last_v;         // last driven byte
	wire        rd_act = !oe_n_in && !ce_n_in && reset_n_in;
	initial
	begin
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'hff;
		st_q = 3'd0; // array read at power-up
		pd_q = 8'h00;
		tgl_q = 1'b0;
		cnt_q = 0;
		last_v = 8'h00;
	end
	// ****
	// command and read events
	// ****
	always @(posedge we_n_in or posedge ce_n_in or posedge rd_act or negedge reset_n_in)
	begin
		if (!reset_n_in)
			st_q <= 3'd0; // pin reset back to array read
		else if (rd_act)
		begin
			if (st_q == 3'd5) // self-timed, ends after reads
			begin
				tgl_q <= ~tgl_q;
				cnt_q <= cnt_q + 1;
				if (cnt_q == PROG_READS)
					st_q <= 3'd0;
			end
		end
		else if (oe_n_in && (we_n_in ^ ce_n_in)) // first rising strobe
		begin
			if (st_q == 3'd5)
				st_q <= 3'd5; // discarded
			else if (st_q == 3'd3)
			begin
				mem[addr_in] <= mem[addr_in] & dq_in;
				pd_q <= dq_in;
				cnt_q <= 0;
				st_q <= 3'd5; // fourth cycle starts, any data byte
			end
			else if (dq_in == `FCSM_RESET_DATA)
				st_q <= 3'd0; // any address
			else if (st_q == 3'd0 && addr_in[10:0] == 11'h555 && dq_in == 8'haa)
				st_q <= 3'd1; // unlock first
			else if (st_q == 3'd1 && addr_in[10:0] == 11'h2aa && dq_in == 8'h55)
				st_q <= 3'd2;
			else if (st_q == 3'd2 && addr_in[10:0] == 11'h555 && dq_in == `FCSM_PROG_DATA)
				st_q <= 3'd3;
			else if (st_q == 3'd2 && addr_in[10:0] == 11'h555 && dq_in == `FCSM_AUTOSEL_DATA)
				st_q <= 3'd4;
			else
				st_q <= 3'd0;
		end
	end
	// read data path
	always @*
	begin
		if (st_q == 3'd5)
			rd_v = {~pd_q[7], tgl_q, 6'h00};
		else if (st_q == 3'd4)
			case (addr_in[7:0])
				8'h00: rd_v = MFR_CODE;
				8'h01: rd_v = DEV_CODE;
				8'h03: rd_v = CONT_CODE;
				default: rd_v = 8'h00;
			endcase
		else
			rd_v = mem[addr_in]; // no sector is ever suspended
	end
	always @(negedge rd_act)
		last_v <= rd_v;
	assign dq_out = rd_act ? rd_v : ~last_v; // released bus shows no stale byte
endmodule
`default_nettype wire

// file: fcsm_host_tb.sv
// testbench: program, readback, autoselect and reset through the port
// assumes fcsm_host with the flash model on its pins
`timescale 1ns/10ps
`default_nettype none
`include "fcsm_host_defs.vh"
module fcsm_host_tb;
	logic clk, rst, wr, rd, rd_seen, oe, ce_n, oe_n, we_n, rs_n, busy;
	logic [3:0] ra;
	logic [31:0] wd, rdata, seed, e, m;
	logic [16:0] fa, a0;
	logic [7:0] fdo, fdi;
	logic [7:0] sh [logic [16:0]]; // expected array
	logic [31:0] exp_q [$];
	logic [31:0] msk_q [$];
	logic [7:0] ids [4] = '{8'h5a, 8'hc3, 8'h00, 8'h3e};
	int err_total = 0, n_compared = 0;
	fcsm_host i_dut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .flash_addr_out(fa),
		.flash_dq_out(fdo), .flash_dq_oe_out(oe), .flash_dq_in(fdi), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_reset_n_out(rs_n),
		.busy_out(busy));
	fcsm_flash_model i_flash (.addr_in(fa), .dq_in(oe ? fdo : ~fdo), .ce_n_in(ce_n),
		.oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(rs_n), .dq_out(fdi));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
		exp_q.push_back(x);
		msk_q.push_back(k);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic cmd(input logic [2:0] c);
		wreg(`FCSM_REG_CTRL, {29'h0, c});
		repeat (2) @(posedge clk);
		for (int i = 0; i < 20000 && busy !== 1'b0; i++)
			@(posedge clk);
		if (busy !== 1'b0)
		begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic readback(input logic [16:0] a);
		wreg(`FCSM_REG_ADDR, {15'h0, a});
		cmd(`FCSM_CMD_READ);
		rreg(`FCSM_REG_RDATA, {24'h0, sh.exists(a) ? sh[a] : 8'hff}, 32'hff);
	endtask
	task automatic prog(input logic [16:0] a, input logic [7:0] d);
		logic [7:0] old;
		old = sh.exists(a) ? sh[a] : 8'hff;
		sh[a] = old & d;
		wreg(`FCSM_REG_ADDR, {15'h0, a});
		wreg(`FCSM_REG_DATA, {24'h0, d});
		cmd(`FCSM_CMD_PROGRAM);
		rreg(`FCSM_REG_STATUS, ((old & d) == d) ? 32'h1 : 32'h5, 32'h7);
		wreg(`FCSM_REG_STATUS, 32'h7);
	endtask
	// scoreboard: oldest note against read data
	always @(posedge clk)
	begin
		rd_seen <= rd;
		if (rd_seen)
		begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			n_compared++;
			if ((rdata & m) !== (e & m))
			begin
				err_total++;
				$display("[ERR] %0t got %h expected %h", $time, rdata & m, e & m);
			end
		end
	end
	initial
	begin
		{rst, wr, rd, rd_seen, ra, wd} = {1'b1, 3'b000, 4'h0, 32'h0};
		seed = 32'h0f10a8c7;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rreg(`FCSM_REG_RDATA, 32'h0, 32'hffffffff);
		rreg(`FCSM_REG_STATUS, 32'h0, 32'h11f);
		for (int k = 0; k < 4; k++)
		begin
			seed = xs(seed);
			a0 = seed[16:0];
			prog(a0, seed[24:17]);
			rreg(`FCSM_REG_DATA, {24'h0, seed[24:17]}, 32'hffffffff);
			readback(a0);
			prog(a0, ~seed[24:17]);
			readback(a0);
		end
		cmd(`FCSM_CMD_AUTOSEL);
		rreg(`FCSM_REG_STATUS, 32'h11, 32'h1f);
		for (int k = 0; k < 8; k++)
		begin
			seed = xs(seed);
			wreg(`FCSM_REG_ADDR, {15'h0, seed[16:8], 6'h0, k[1:0]});
			cmd(`FCSM_CMD_ASREAD);
			rreg(`FCSM_REG_RDATA, {24'h0, ids[k % 4]}, 32'hff);
		end
		wreg(`FCSM_REG_ADDR, {15'h0, seed[30:14]});
		rreg(`FCSM_REG_ADDR, {15'h0, seed[30:14]}, 32'hffffffff);
		cmd(`FCSM_CMD_RESET);
		rreg(`FCSM_REG_CTRL, {29'h0, `FCSM_CMD_RESET}, 32'hffffffff);
		rreg(`FCSM_REG_STATUS, 32'h1, 32'h1f);
		readback(17'h1fff4);
		cmd(`FCSM_CMD_AUTOSEL);
		wreg(`FCSM_REG_STATUS, 32'h100);
		rreg(`FCSM_REG_STATUS, 32'h100, 32'h100);
		wreg(`FCSM_REG_STATUS, 32'h0);
		readback(17'h1fff4);
		readback(a0);
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
`default_nettype wire
